// ### design/epr_regs.vh
// Constants for the page permission restriction engine.
// Assumes inclusion by every design file of the block but the address checker.
`ifndef EPR_REGS_VH
`define EPR_REGS_VH
// -----------------------------------------------------------------
// Register offsets (APB byte addresses)
// -----------------------------------------------------------------
`define EPR_OFF_CTRL      12'h000
`define EPR_OFF_LEAF      12'h004
`define EPR_OFF_DESC_LO   12'h008
`define EPR_OFF_DESC_HI   12'h00C
`define EPR_OFF_TGT_LO    12'h010
`define EPR_OFF_TGT_HI    12'h014
`define EPR_OFF_RESULT    12'h018
`define EPR_OFF_FLAGS     12'h01C
`define EPR_OFF_FAULT_LO  12'h020
`define EPR_OFF_FAULT_HI  12'h024
`define EPR_OFF_IRQ_STAT  12'h028
`define EPR_OFF_IRQ_MASK  12'h02C
`define EPR_OFF_LIMIT_LO  12'h030
`define EPR_OFF_LIMIT_HI  12'h034
`define EPR_OFF_MODE      12'h038
// -----------------------------------------------------------------
// Fields and codes
// -----------------------------------------------------------------
`define EPR_LEAF_RESTRICT 32'h0000000E
`define EPR_RC_OK         32'h00000000
`define EPR_FAULT_NONE    2'h0
`define EPR_FAULT_GP      2'h1
`define EPR_FAULT_PF      2'h2
`define EPR_FAULT_UD      2'h3
// Descriptor flag bits in the low word
`define EPR_SI_R          0
`define EPR_SI_W          1
`define EPR_SI_X          2
`define EPR_SI_RSVD_MASK  64'hFFFFFFFFFFFFFFF8
// Page map entry bit positions
`define EPR_PM_R          0
`define EPR_PM_W          1
`define EPR_PM_X          2
`define EPR_PM_VALID      3
`define EPR_PM_PEND       4
`define EPR_PM_MOD        5
`define EPR_PM_RIP        6
`define EPR_PM_PT_LO      8
`define EPR_PM_PT_HI      15
`define EPR_REGULAR_PAGE_TYPE        8'h01
// Status / interrupt bits
`define EPR_IRQ_DONE      0
`define EPR_IRQ_FAULT     1
`define EPR_IRQ_ABORT     2
`define EPR_SCR_WORDS     8
`endif

// ### design/epr_addr_chk.v
// Operand address checker: alignment, limit and canonical form.
// Assumes addresses are 64-bit effective addresses on i_clk domain.
`timescale 1ns/10ps
module epr_addr_chk (
   input  wire [63:0] i_desc_addr,
   input  wire [63:0] i_tgt_addr,
   input  wire [63:0] i_seg_limit,
   input  wire        i_mode64,
   output wire        o_desc_misal,
   output wire        o_tgt_misal,
   output wire        o_bad_ea
);
   // -----------------------------------------------------------------
   // Canonical test, used on both operands
   // -----------------------------------------------------------------
   function canon_bad;
      input [63:0] a;
      begin
         canon_bad = (a[63:47] != 17'h00000) && (a[63:47] != 17'h1FFFF);
      end
   endfunction

   // Descriptor 64-byte, target 4-kilobyte alignment
   assign o_desc_misal = (i_desc_addr[5:0] != 6'h00);
   assign o_tgt_misal  = (i_tgt_addr[11:0] != 12'h000);
   // Segment limit outside 64-bit mode, canonical form inside it
   assign o_bad_ea = i_mode64 ?
      (canon_bad(i_desc_addr) | canon_bad(i_tgt_addr)) :
      ((i_desc_addr > i_seg_limit) | (i_tgt_addr > i_seg_limit));
endmodule // epr_addr_chk

// ### design/epr_apb_regs.v
// APB slave decode helper: select and error for unmapped offsets.
// Assumes a 12-bit byte address, 32-bit words, zero-wait answers.
`timescale 1ns/10ps
`include "epr_regs.vh"
module epr_apb_regs (
   input  wire [11:0] i_paddr,
   input  wire        i_psel,
   input  wire        i_penable,
   input  wire        i_pwrite,
   output wire        o_wr_en,
   output wire        o_rd_en,
   output wire        o_mapped
);
   // Only aligned words up to the last register are mapped
   assign o_mapped = (i_paddr[1:0] == 2'h0) &&
                     (i_paddr <= `EPR_OFF_MODE);
   assign o_wr_en  = i_psel & i_penable & i_pwrite & o_mapped;
   assign o_rd_en  = i_psel & i_penable & ~i_pwrite;
endmodule // epr_apb_regs

// ### design/epr_engine.v
// Permission restriction engine: checks operands, descriptor and page
// map state, then narrows permissions of a regular page.
// Assumes memory fetch, page map and concurrency status arrive as ports.
`timescale 1ns/10ps
`include "epr_regs.vh"
module epr_engine #(
   parameter [31:0] PAGE_CONFLICT_CODE = 32'h00000007,
   parameter [31:0] PAGE_LOCKED_CODE   = 32'h00000015
) (
   input  wire        i_clk,
   input  wire        i_rst,
   // APB slave
   input  wire [11:0] i_paddr,
   input  wire        i_psel,
   input  wire        i_penable,
   input  wire        i_pwrite,
   input  wire [31:0] i_pwdata,
   output reg  [31:0] o_prdata,
   output wire        o_pready,
   output wire        o_pslverr,
   // Issuing context
   input  wire [1:0]  i_priv_level,
   // Descriptor fetch, one 64-bit word per beat
   output reg         o_desc_req,
   output reg  [2:0]  o_desc_idx,
   input  wire        i_desc_vld,
   input  wire [63:0] i_desc_data,
   // Page map lookup and write-back
   input  wire        i_tgt_in_cache,
   input  wire [15:0] i_pm_entry,
   output reg         o_pm_we,
   output reg  [15:0] o_pm_wdata,
   // Concurrency and owner state
   input  wire        i_gen1_busy,
   input  wire        i_gen2_other,
   input  wire        i_gen2_conflict,
   input  wire        i_page_written,
   input  wire        i_owner_init,
   // Interrupt
   output wire        o_irq
);
   // -----------------------------------------------------------------
   // States
   // -----------------------------------------------------------------
   localparam [5:0] ST_IDLE  = 6'h01;
   localparam [5:0] ST_ADDR  = 6'h02;
   localparam [5:0] ST_FETCH = 6'h04;
   localparam [5:0] ST_CHECK = 6'h08;
   localparam [5:0] ST_PAGE  = 6'h10;
   localparam [5:0] ST_DONE  = 6'h20;

   reg  [5:0]  state_r;
   reg  [5:0]  state_nxt;
   reg  [63:0] scratch_r [0:`EPR_SCR_WORDS-1];
   reg  [2:0]  idx_r;
   reg  [31:0] leaf_r;
   reg  [63:0] desc_addr_r;
   reg  [63:0] tgt_addr_r;
   reg  [63:0] limit_r;
   reg         mode64_r;
   reg  [31:0] result_r;
   reg         zero_flag_r;
   reg  [4:0]  arith_r;       // Carry, parity, aux, overflow, sign
   reg  [1:0]  fault_r;
   reg  [63:0] fault_addr_r;
   reg  [2:0]  irq_stat_r;
   reg  [2:0]  irq_mask_r;
   reg         busy_r;
   reg         start_p;
   reg  [2:0]  ev_set;
   reg  [63:0] rsvd_or;
   integer     k;
   integer     j;

   wire        wr_en;
   wire        rd_en;
   wire        mapped;
   wire        desc_misal;
   wire        tgt_misal;
   wire        bad_ea;

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function [63:0] put_lo;
      input [63:0] old;
      input [31:0] d;
      begin
         put_lo = {old[63:32], d};
      end
   endfunction

   function [63:0] put_hi;
      input [63:0] old;
      input [31:0] d;
      begin
         put_hi = {d, old[31:0]};
      end
   endfunction

   epr_apb_regs u_dec (
      .i_paddr   (i_paddr),
      .i_psel    (i_psel),
      .i_penable (i_penable),
      .i_pwrite  (i_pwrite),
      .o_wr_en   (wr_en),
      .o_rd_en   (rd_en),
      .o_mapped  (mapped)
   );

   epr_addr_chk u_chk (
      .i_desc_addr  (desc_addr_r),
      .i_tgt_addr   (tgt_addr_r),
      .i_seg_limit  (limit_r),
      .i_mode64     (mode64_r),
      .o_desc_misal (desc_misal),
      .o_tgt_misal  (tgt_misal),
      .o_bad_ea     (bad_ea)
   );

   // Zero-wait slave; unmapped offsets answer with an error
   assign o_pready  = 1'b1;
   assign o_pslverr = i_psel & i_penable & ~mapped;
   assign o_irq     = |(irq_stat_r & irq_mask_r);

   // -----------------------------------------------------------------
   // Register writes from software
   // -----------------------------------------------------------------
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         leaf_r      <= 32'h00000000;
         desc_addr_r <= 64'h0000000000000000;
         tgt_addr_r  <= 64'h0000000000000000;
         limit_r     <= 64'hFFFFFFFFFFFFFFFF;
         mode64_r    <= 1'b0;
         irq_mask_r  <= 3'h0;
         start_p     <= 1'b0;
      end else begin
         start_p <= wr_en && (i_paddr == `EPR_OFF_CTRL) && i_pwdata[0]
                    && !busy_r;
         if (wr_en) begin
            case (i_paddr)
               `EPR_OFF_LEAF:     leaf_r      <= i_pwdata;
               `EPR_OFF_DESC_LO:  desc_addr_r <= put_lo(desc_addr_r, i_pwdata);
               `EPR_OFF_DESC_HI:  desc_addr_r <= put_hi(desc_addr_r, i_pwdata);
               `EPR_OFF_TGT_LO:   tgt_addr_r  <= put_lo(tgt_addr_r, i_pwdata);
               `EPR_OFF_TGT_HI:   tgt_addr_r  <= put_hi(tgt_addr_r, i_pwdata);
               `EPR_OFF_LIMIT_LO: limit_r     <= put_lo(limit_r, i_pwdata);
               `EPR_OFF_LIMIT_HI: limit_r     <= put_hi(limit_r, i_pwdata);
               `EPR_OFF_MODE:     mode64_r    <= i_pwdata[0];
               `EPR_OFF_IRQ_MASK: irq_mask_r  <= i_pwdata[2:0];
               default: begin
               end
            endcase
         end
      end
   end

   // -----------------------------------------------------------------
   // Read mux; registered data, sampled on the setup phase
   // -----------------------------------------------------------------
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_prdata <= 32'h00000000;
      end else if (i_psel && !i_penable && !i_pwrite) begin
         case (i_paddr)
            `EPR_OFF_CTRL:     o_prdata <= {31'h00000000, busy_r};
            `EPR_OFF_LEAF:     o_prdata <= leaf_r;
            `EPR_OFF_DESC_LO:  o_prdata <= desc_addr_r[31:0];
            `EPR_OFF_DESC_HI:  o_prdata <= desc_addr_r[63:32];
            `EPR_OFF_TGT_LO:   o_prdata <= tgt_addr_r[31:0];
            `EPR_OFF_TGT_HI:   o_prdata <= tgt_addr_r[63:32];
            `EPR_OFF_RESULT:   o_prdata <= result_r;
            `EPR_OFF_FLAGS:    o_prdata <= {24'h000000, fault_r,
                                            arith_r, zero_flag_r};
            `EPR_OFF_FAULT_LO: o_prdata <= fault_addr_r[31:0];
            `EPR_OFF_FAULT_HI: o_prdata <= fault_addr_r[63:32];
            `EPR_OFF_IRQ_STAT: o_prdata <= {29'h00000000, irq_stat_r};
            `EPR_OFF_IRQ_MASK: o_prdata <= {29'h00000000, irq_mask_r};
            `EPR_OFF_LIMIT_LO: o_prdata <= limit_r[31:0];
            `EPR_OFF_LIMIT_HI: o_prdata <= limit_r[63:32];
            `EPR_OFF_MODE:     o_prdata <= {31'h00000000, mode64_r};
            default:           o_prdata <= 32'h00000000;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Reserved-field reduction over the scratch copy
   // -----------------------------------------------------------------
   always @* begin
      rsvd_or = scratch_r[0] & `EPR_SI_RSVD_MASK;
      for (k = 1; k < `EPR_SCR_WORDS; k = k + 1) begin
         rsvd_or = rsvd_or | scratch_r[k];
      end
   end

   // -----------------------------------------------------------------
   // Sequencer state
   // -----------------------------------------------------------------
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:  if (start_p) state_nxt = ST_ADDR;
         ST_ADDR:  state_nxt = ST_DONE;
         ST_FETCH: if (i_desc_vld && idx_r == 3'h7) state_nxt = ST_CHECK;
         ST_CHECK: state_nxt = ST_DONE;
         ST_PAGE:  state_nxt = ST_DONE;
         ST_DONE:  state_nxt = ST_IDLE;
         default:  state_nxt = ST_IDLE;
      endcase
   end

   // -----------------------------------------------------------------
   // Checks, fetch and commit; first failing check wins, in order
   // -----------------------------------------------------------------
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_r      <= ST_IDLE;
         idx_r        <= 3'h0;
         busy_r       <= 1'b0;
         o_desc_req   <= 1'b0;
         o_desc_idx   <= 3'h0;
         o_pm_we      <= 1'b0;
         o_pm_wdata   <= 16'h0000;
         result_r     <= 32'h00000000;
         zero_flag_r  <= 1'b0;
         arith_r      <= 5'h00;
         fault_r      <= `EPR_FAULT_NONE;
         fault_addr_r <= 64'h0000000000000000;
         ev_set       <= 3'h0;
         for (j = 0; j < `EPR_SCR_WORDS; j = j + 1)
            scratch_r[j] <= 64'h0000000000000000;
      end else begin
         state_r <= state_nxt;
         o_pm_we <= 1'b0;
         ev_set  <= 3'h0;
         case (state_r)
            ST_IDLE: begin
               if (start_p) begin
                  busy_r       <= 1'b1;
                  fault_r      <= `EPR_FAULT_NONE;
                  fault_addr_r <= 64'h0000000000000000;
               end
            end
            ST_ADDR: begin
               if (leaf_r != `EPR_LEAF_RESTRICT || i_priv_level != 2'h0)
                  fault_r <= `EPR_FAULT_UD;
               else if (bad_ea)
                  fault_r <= `EPR_FAULT_GP;
               else if (desc_misal)
                  fault_r <= `EPR_FAULT_GP;
               else if (tgt_misal)
                  fault_r <= `EPR_FAULT_GP;
               else if (!i_tgt_in_cache) begin
                  fault_r      <= `EPR_FAULT_PF;
                  fault_addr_r <= tgt_addr_r;
               end else begin
                  state_r    <= ST_FETCH;
                  idx_r      <= 3'h0;
                  o_desc_req <= 1'b1;
                  o_desc_idx <= 3'h0;
               end
            end
            ST_FETCH: begin
               if (i_desc_vld) begin
                  scratch_r[idx_r] <= i_desc_data;
                  idx_r            <= idx_r + 3'h1;
                  o_desc_idx       <= idx_r + 3'h1;
                  if (idx_r == 3'h7)
                     o_desc_req <= 1'b0;
               end
            end
            ST_CHECK: begin
               if ((rsvd_or != 64'h0000000000000000) ||
                   (!scratch_r[0][`EPR_SI_R] && scratch_r[0][`EPR_SI_W]))
                  fault_r <= `EPR_FAULT_GP;
               else if (i_gen1_busy || i_gen2_other)
                  fault_r <= `EPR_FAULT_GP;
               else
                  state_r <= ST_PAGE;
            end
            ST_PAGE: begin
               if (!i_pm_entry[`EPR_PM_VALID]) begin
                  fault_r      <= `EPR_FAULT_PF;
                  fault_addr_r <= tgt_addr_r;
               end else if (i_gen2_conflict || i_page_written) begin
                  zero_flag_r <= 1'b1;
                  result_r    <= PAGE_CONFLICT_CODE;
               end else if (i_pm_entry[`EPR_PM_PEND] ||
                            i_pm_entry[`EPR_PM_MOD]) begin
                  zero_flag_r <= 1'b1;
                  result_r    <= PAGE_LOCKED_CODE;
               end else if (i_pm_entry[`EPR_PM_PT_HI:`EPR_PM_PT_LO] !=
                            `EPR_REGULAR_PAGE_TYPE) begin
                  fault_r      <= `EPR_FAULT_PF;
                  fault_addr_r <= tgt_addr_r;
               end else if (!i_owner_init)
                  fault_r <= `EPR_FAULT_GP;
               else begin
                  o_pm_we    <= 1'b1;
                  o_pm_wdata <= {i_pm_entry[15:7], 1'b1,
                                 i_pm_entry[5:3],
                                 i_pm_entry[2:0] & scratch_r[0][2:0]};
                  zero_flag_r <= 1'b0;
                  result_r    <= `EPR_RC_OK;
               end
            end
            ST_DONE: begin
               arith_r <= 5'h00;
               busy_r  <= 1'b0;
               if (fault_r != `EPR_FAULT_NONE)
                  ev_set <= 3'h2;
               else if (zero_flag_r)
                  ev_set <= 3'h4;
               else
                  ev_set <= 3'h1;
            end
            default: begin
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Sticky interrupt status; a new event beats a same-cycle clear
   // -----------------------------------------------------------------
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst)
         irq_stat_r <= 3'h0;
      else if (wr_en && i_paddr == `EPR_OFF_IRQ_STAT)
         irq_stat_r <= (irq_stat_r & ~i_pwdata[2:0]) | ev_set;
      else
         irq_stat_r <= irq_stat_r | ev_set;
   end
endmodule // epr_engine

// ### sim/epr_engine_properties.sv
// Port-level checks of the permission restriction engine.
// Assumes binding onto epr_engine; one clock, async high reset.
`timescale 1ns/10ps
`include "epr_regs.vh"
module epr_engine_props (
   input wire logic        i_clk,
   input wire logic        i_rst,
   input wire logic [11:0] i_paddr,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   input wire logic [1:0]  i_priv_level,
   input wire logic        o_desc_req,
   input wire logic [2:0]  o_desc_idx,
   input wire logic        i_desc_vld,
   input wire logic [63:0] i_desc_data,
   input wire logic        i_tgt_in_cache,
   input wire logic [15:0] i_pm_entry,
   input wire logic        o_pm_we,
   input wire logic [15:0] o_pm_wdata,
   input wire logic        i_gen1_busy,
   input wire logic        i_gen2_other,
   input wire logic        i_gen2_conflict,
   input wire logic        i_page_written,
   input wire logic        i_owner_init,
   input wire logic        o_irq
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // ---------------------------------------------------------------
   // Bus answers
   // ---------------------------------------------------------------
   unmapped_err_a: assert property (i_psel && i_penable &&
      i_paddr > 12'h038 |-> o_pslverr) else $error("no error on hole");
   mapped_ok_a: assert property (i_psel && i_penable && i_paddr <= 12'h038
      && i_paddr[1:0] == 2'h0 |-> !o_pslverr) else $error("error on reg");
   // ---------------------------------------------------------------
   // Descriptor fetch only for a legal request in the page cache
   // ---------------------------------------------------------------
   fetch_priv_a: assert property (
      o_desc_req |-> i_priv_level == 2'h0) else $error("fetch at priv");
   fetch_cache_a: assert property (
      o_desc_req |-> i_tgt_in_cache) else $error("fetch outside cache");
   fetch_start_a: assert property (
      $rose(o_desc_req) |-> o_desc_idx == 3'h0) else $error("bad first");
   fetch_step_a: assert property (
      o_desc_req && i_desc_vld && o_desc_idx != 3'h7 |=> o_desc_req &&
      o_desc_idx == $past(o_desc_idx) + 3'h1) else $error("bad step");
   // ---------------------------------------------------------------
   // Page map commit: cause and content
   // ---------------------------------------------------------------
   pm_pulse_a: assert property (
      o_pm_we |=> !o_pm_we) else $error("write held");
   pm_flag_set_a: assert property (
      o_pm_we |-> o_pm_wdata[`EPR_PM_RIP] && o_pm_wdata[`EPR_PM_VALID] &&
      o_pm_wdata[15:8] == `EPR_REGULAR_PAGE_TYPE) else $error("bad entry");
   pm_narrow_a: assert property (
      o_pm_we |-> (o_pm_wdata[2:0] & ~i_pm_entry[2:0]) == 3'h0)
      else $error("rights widened");
   pm_cause_a: assert property (
      o_pm_we |-> i_pm_entry[3] && !i_pm_entry[4] && !i_pm_entry[5] &&
      i_pm_entry[15:8] == `EPR_REGULAR_PAGE_TYPE && i_owner_init && !i_gen2_conflict)
      else $error("commit on bad page");
   pm_busy_a: assert property (
      o_pm_we |-> !(i_gen1_busy || i_gen2_other || i_page_written))
      else $error("commit while busy");
endmodule // epr_engine_props

// ### sim/test_epr_engine.sv
// Self-checking bench of the permission restriction engine.
// Assumes epr_engine with zero-wait APB; bench serves descriptor words.
`timescale 1ns/10ps
`include "epr_regs.vh"
module test_epr_engine;
   logic        i_clk, i_rst, i_psel, i_penable, i_pwrite, i_desc_vld;
   logic [11:0] i_paddr;
   logic [31:0] i_pwdata, o_prdata, g_da, g_ta, g_thi, q;
   logic [1:0]  i_priv_level, g_priv;
   logic [63:0] i_desc_data;
   logic [63:0] desc_w [0:7];
   logic [15:0] i_pm_entry, o_pm_wdata, g_pm, pm_seen;
   logic [7:0]  g_leaf;
   logic [5:0]  g_cd;
   logic        o_pready, o_pslverr, o_desc_req, o_pm_we, o_irq, serr;
   logic        i_tgt_in_cache, i_gen1_busy, i_gen2_other;
   logic        i_gen2_conflict, i_page_written, i_owner_init;
   logic [2:0]  o_desc_idx;
   integer      num_errors, checked, pm_cnt, tnum;

   epr_engine dut (.i_clk(i_clk), .i_rst(i_rst), .i_paddr(i_paddr),
      .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
      .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
      .o_pslverr(o_pslverr), .i_priv_level(i_priv_level),
      .o_desc_req(o_desc_req), .o_desc_idx(o_desc_idx),
      .i_desc_vld(i_desc_vld), .i_desc_data(i_desc_data),
      .i_tgt_in_cache(i_tgt_in_cache), .i_pm_entry(i_pm_entry),
      .o_pm_we(o_pm_we), .o_pm_wdata(o_pm_wdata),
      .i_gen1_busy(i_gen1_busy), .i_gen2_other(i_gen2_other),
      .i_gen2_conflict(i_gen2_conflict), .i_page_written(i_page_written),
      .i_owner_init(i_owner_init), .o_irq(o_irq));

   // Clock, 40 ns period
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   // ---------------------------------------------------------------
   // Far side: one descriptor word every other cycle, commit monitor
   // ---------------------------------------------------------------
   always @(posedge i_clk) begin
      if (o_desc_req && !i_desc_vld) begin
         i_desc_vld  <= 1'b1;
         i_desc_data <= desc_w[o_desc_idx];
      end else begin
         i_desc_vld  <= 1'b0;
         i_desc_data <= ~i_desc_data; // Stale word never looks valid
      end
      if (o_pm_we) begin
         pm_cnt  <= pm_cnt + 1;
         pm_seen <= o_pm_wdata;
      end
   end
   // ---------------------------------------------------------------
   // Reporting
   // ---------------------------------------------------------------
   task chk(input logic [63:0] got, input logic [63:0] exp);
      checked = checked + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("BAD %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // APB master; request held until pready seen at the edge
   // ---------------------------------------------------------------
   task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      integer n;
      @(posedge i_clk);
      i_psel    <= 1'b1;
      i_penable <= 1'b0;
      i_paddr   <= a;
      i_pwrite  <= w;
      i_pwdata  <= d;
      @(posedge i_clk);
      i_penable <= 1'b1;
      n = 0;
      // Request stands until pready is seen at a rising edge
      do begin
         @(posedge i_clk);
         n = n + 1;
      end while (o_pready !== 1'b1 && n < 50);
      q = o_prdata;
      serr = o_pslverr;
      if (n >= 50) begin
         num_errors = num_errors + 1;
         end_sim;
      end
      i_psel    <= 1'b0;
      i_penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask
   task irq_is(input logic v);
      @(negedge i_clk);
      chk(o_irq, v);
   endtask
   task dflt;
      g_leaf = 8'h0E;
      g_priv = 2'h0;
      g_da = 32'h00001000;
      g_ta = 32'h00002000;
      g_thi = 32'h00000000;
      g_pm = 16'h010F;
      g_cd = 6'h30; // {init, in cache, gen1, other, written, conflict}
      for (int i = 0; i < 8; i++)
         desc_w[i] = 64'h0;
      desc_w[0] = 64'h5;
   endtask
   // ---------------------------------------------------------------
   // One operation: expected fault, code, zero flag, new entry
   // ---------------------------------------------------------------
   task tc(input logic [1:0] ef, input logic [7:0] rc, input logic zf,
           input logic [15:0] epm);
      integer n, c0;
      @(posedge i_clk);
      i_priv_level <= g_priv;
      i_pm_entry   <= g_pm;
      {i_owner_init, i_tgt_in_cache, i_gen1_busy, i_gen2_other,
       i_page_written, i_gen2_conflict} <= g_cd;
      wr(`EPR_OFF_LEAF, {24'h0, g_leaf});
      wr(`EPR_OFF_DESC_LO, g_da);
      wr(`EPR_OFF_DESC_HI, 32'h0);
      wr(`EPR_OFF_TGT_LO, g_ta);
      wr(`EPR_OFF_TGT_HI, g_thi);
      c0 = pm_cnt;
      wr(`EPR_OFF_CTRL, 32'h1);
      n = 0;
      // Interrupt, unmasked, marks completion
      while (o_irq !== 1'b1 && n < 400) begin
         @(negedge i_clk);
         n = n + 1;
      end
      if (n >= 400) begin
         num_errors = num_errors + 1;
         end_sim;
      end
      apb(`EPR_OFF_FLAGS, 1'b0, 32'h0);
      chk(q[5:1], 5'h0);
      chk(q[7:6], ef);
      if (ef == `EPR_FAULT_NONE) begin
         chk(q[0], zf);
         apb(`EPR_OFF_RESULT, 1'b0, 32'h0);
         chk(q, {24'h0, rc});
      end
      if (ef == `EPR_FAULT_PF) begin
         apb(`EPR_OFF_FAULT_LO, 1'b0, 32'h0);
         chk(q, g_ta);
      end
      chk(pm_cnt - c0, epm != 16'h0);
      if (epm != 16'h0)
         chk(pm_seen, epm);
      apb(`EPR_OFF_IRQ_STAT, 1'b0, 32'h0);
      chk(q[2:0], ef != 2'h0 ? 3'h2 : (zf ? 3'h4 : 3'h1));
      // Masking hides a pending event; a one clears it
      wr(`EPR_OFF_IRQ_MASK, 32'h0);
      irq_is(1'b0);
      wr(`EPR_OFF_IRQ_MASK, 32'h7);
      irq_is(1'b1);
      wr(`EPR_OFF_IRQ_STAT, 32'h7);
      irq_is(1'b0);
      dflt;
      tnum = tnum + 1;
      $display("test %0d done", tnum);
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {i_rst, i_psel, i_penable, i_pwrite, i_desc_vld} = 5'h10;
      {i_paddr, i_pwdata, i_desc_data} = 108'h0;
      {i_priv_level, i_pm_entry, i_tgt_in_cache, i_owner_init} = 20'h0;
      {i_gen1_busy, i_gen2_other, i_gen2_conflict, i_page_written} = 4'h0;
      {num_errors, checked, pm_cnt, tnum} = 128'h0;
      dflt;
      repeat (3) @(posedge i_clk);
      i_rst <= 1'b0;
      apb(`EPR_OFF_LIMIT_LO, 1'b0, 32'h0);
      chk(q, 32'hFFFFFFFF);
      apb(12'h040, 1'b0, 32'h0);
      chk(serr, 1'b1);
      apb(12'h006, 1'b0, 32'h0);
      chk(serr, 1'b1);
      apb(`EPR_OFF_RESULT, 1'b0, 32'h0);
      chk(serr, 1'b0);
      wr(`EPR_OFF_IRQ_MASK, 32'h7);
      tc(2'h0, 8'h00, 1'b0, 16'h014D);
      desc_w[0] = 64'h7;
      tc(2'h0, 8'h00, 1'b0, 16'h014F);
      g_cd = 6'h31;
      tc(2'h0, 8'h07, 1'b1, 16'h0000);
      g_pm = 16'h0109;
      desc_w[0] = 64'h1;
      tc(2'h0, 8'h00, 1'b0, 16'h0149);
      g_leaf = 8'h0F;
      tc(2'h3, 8'h00, 1'b0, 16'h0000);
      g_priv = 2'h3;
      tc(2'h3, 8'h00, 1'b0, 16'h0000);
      g_da = 32'h00001020;
      tc(2'h1, 8'h00, 1'b0, 16'h0000);
      g_ta = 32'h00002800;
      tc(2'h1, 8'h00, 1'b0, 16'h0000);
      g_cd = 6'h20;
      tc(2'h2, 8'h00, 1'b0, 16'h0000);
      desc_w[0] = 64'hD;
      tc(2'h1, 8'h00, 1'b0, 16'h0000);
      desc_w[0] = 64'h2;
      tc(2'h1, 8'h00, 1'b0, 16'h0000);
      desc_w[7] = 64'h8000000000000000;
      tc(2'h1, 8'h00, 1'b0, 16'h0000);
      g_cd = 6'h38;
      tc(2'h1, 8'h00, 1'b0, 16'h0000);
      g_cd = 6'h34;
      tc(2'h1, 8'h00, 1'b0, 16'h0000);
      g_cd = 6'h32;
      tc(2'h0, 8'h07, 1'b1, 16'h0000);
      g_pm = 16'h0107;
      tc(2'h2, 8'h00, 1'b0, 16'h0000);
      g_pm = 16'h011F;
      tc(2'h0, 8'h15, 1'b1, 16'h0000);
      g_pm = 16'h012F;
      tc(2'h0, 8'h15, 1'b1, 16'h0000);
      g_pm = 16'h020F;
      tc(2'h2, 8'h00, 1'b0, 16'h0000);
      g_cd = 6'h10;
      tc(2'h1, 8'h00, 1'b0, 16'h0000);
      wr(`EPR_OFF_LIMIT_HI, 32'h00000000);
      g_thi = 32'h00000001;
      tc(2'h1, 8'h00, 1'b0, 16'h0000);
      wr(`EPR_OFF_MODE, 32'h1);
      g_thi = 32'h00800000;
      tc(2'h1, 8'h00, 1'b0, 16'h0000);
      tc(2'h0, 8'h00, 1'b0, 16'h014D);
      end_sim;
   end
endmodule // test_epr_engine

bind epr_engine epr_engine_props u_props (.i_clk(i_clk), .i_rst(i_rst),
   .i_paddr(i_paddr), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr),
   .i_priv_level(i_priv_level), .o_desc_req(o_desc_req),
   .o_desc_idx(o_desc_idx), .i_desc_vld(i_desc_vld),
   .i_desc_data(i_desc_data), .i_tgt_in_cache(i_tgt_in_cache),
   .i_pm_entry(i_pm_entry), .o_pm_we(o_pm_we), .o_pm_wdata(o_pm_wdata),
   .i_gen1_busy(i_gen1_busy), .i_gen2_other(i_gen2_other),
   .i_gen2_conflict(i_gen2_conflict), .i_page_written(i_page_written),
   .i_owner_init(i_owner_init), .o_irq(o_irq));
